/* File: rtl/link_loss_supervisor.sv */
// Ethernet link-loss supervisor with APB registers and interrupt
`timescale 1ns/1ns
module link_loss_supervisor
  import link_sup_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // PHY link status pins
  input wire logic first_eth_port_link_up,
  input wire logic second_eth_port_link_up,
  // Drive state
  input wire logic drive_running,
  input wire logic drive_reset_active,
  input wire logic cyclic_active,
  input wire logic speed_cfg_changed,
  input wire logic ip_cfg_changed,
  // TCP/IP stack
  input wire logic tcp_open,
  input wire logic peer_response,
  input wire logic dup_ip_detected,
  // Indications
  output logic link_loss_warning,
  output logic alarm_output,
  output logic link_loss_fault,
  output link_sup_pkg::panel_t panel_code,
  output logic duplicate_addr_fault,
  output logic dup_check_req,
  output logic snmp_enable,
  output logic relay_enable,
  output logic keepalive_send,
  output logic tcp_force_close,
  output logic irq
);
  import link_sup_pkg::*;

  // ********************************
  // Registers and nets
  // ********************************
  logic [31:0] cfg_loss_r;
  logic [31:0] cfg_net_r;
  logic [31:0] ka_interval_r;
  logic [31:0] slot01_r;
  logic [31:0] slot23_r;
  logic [IRQ_W-1:0] irq_stat_r;
  logic [IRQ_W-1:0] irq_mask_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic [1:0] meta_r;
  logic [1:0] sync_r;
  logic [1:0] prev_r;
  logic warn_r;
  logic alarm_r;
  logic fault_r;
  logic fault_nxt;
  panel_t panel_r;
  logic dup_r;
  logic dup_req_r;
  logic snmp_r;
  logic relay_r;
  logic cfg_chg_r;
  logic reset_prev_r;
  logic irq_r;
  logic [1:0] loss;
  logic [1:0] link_rise;
  logic [2:0] path;
  logic trip_req;
  logic wr_en;
  logic setup;
  logic clr_link;
  logic clr_dup;
  logic addr_ok;
  logic dup_en;
  logic snmp_sel;
  logic slot_block;
  logic [IRQ_W-1:0] irq_evt;
  loss_act_t act1;
  logic [15:0] sel2;
  logic [15:0] diag_sel;
  logic [15:0] relay_sel;
  keepalive_if ka ();

  assign act1 = loss_act_t'(cfg_loss_r[ACT_LSB +: 2]);
  assign sel2 = cfg_loss_r[SEL2_LSB +: 16];
  assign diag_sel = cfg_net_r[DIAG_LSB +: 16];
  assign relay_sel = cfg_net_r[RELAY_LSB +: 16];

  // ********************************
  // APB slave
  // ********************************
  assign setup = psel && !penable;
  assign wr_en = psel && penable && pready_r && pwrite;
  assign clr_link = wr_en && paddr == ADDR_CMD && pwdata[CMD_CLR_LINK];
  assign clr_dup = wr_en && paddr == ADDR_CMD && pwdata[CMD_CLR_DUP];

  always_comb begin
    unique case (paddr)
      ADDR_CFG_LOSS, ADDR_CFG_NET, ADDR_KA_INTERVAL, ADDR_SLOT01, ADDR_SLOT23, ADDR_STATUS,
      ADDR_IRQ_STAT, ADDR_IRQ_MASK, ADDR_CMD: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  // Answer in the first access cycle; read data captured at setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0;
    end else begin
      pready_r <= setup;
      pslverr_r <= setup && !addr_ok;
      if (setup && !pwrite) begin
        unique case (paddr)
          ADDR_CFG_LOSS: prdata_r <= cfg_loss_r;
          ADDR_CFG_NET: prdata_r <= cfg_net_r;
          ADDR_KA_INTERVAL: prdata_r <= ka_interval_r;
          ADDR_SLOT01: prdata_r <= slot01_r;
          ADDR_SLOT23: prdata_r <= slot23_r;
          ADDR_STATUS: prdata_r <= {18'h0, ka.probe_cnt, dup_en, relay_r, snmp_r, dup_r, fault_r,
                                    alarm_r, warn_r, 2'h0, sync_r};
          ADDR_IRQ_STAT: prdata_r <= {27'h0, irq_stat_r};
          ADDR_IRQ_MASK: prdata_r <= {27'h0, irq_mask_r};
          default: prdata_r <= 32'h0;
        endcase
      end
    end
  end

  // Configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_loss_r <= CFG_LOSS_RST;
      cfg_net_r <= CFG_NET_RST;
      ka_interval_r <= KA_INTERVAL_RST;
      slot01_r <= SLOT_RST;
      slot23_r <= SLOT_RST;
      irq_mask_r <= IRQ_MASK_RST;
    end else if (wr_en) begin
      unique case (paddr)
        ADDR_CFG_LOSS: cfg_loss_r <= {13'h0, pwdata[STOP_BIT:0]};
        ADDR_CFG_NET: cfg_net_r <= pwdata;
        ADDR_KA_INTERVAL: ka_interval_r <= pwdata;
        ADDR_SLOT01: slot01_r <= pwdata;
        ADDR_SLOT23: slot23_r <= pwdata;
        ADDR_IRQ_MASK: irq_mask_r <= pwdata[IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // ********************************
  // Link status synchroniser
  // ********************************
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_port
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          meta_r[gi] <= 1'b1;
          sync_r[gi] <= 1'b1;
          prev_r[gi] <= 1'b1;
        end else begin
          meta_r[gi] <= gi == 0 ? first_eth_port_link_up : second_eth_port_link_up;
          sync_r[gi] <= meta_r[gi];
          prev_r[gi] <= sync_r[gi];
        end
      end
      assign loss[gi] = !sync_r[gi];
      assign link_rise[gi] = sync_r[gi] && !prev_r[gi];
    end
  endgenerate

  // ********************************
  // Loss evaluation
  // ********************************
  // Returns {trip, alarm, warning} for one action and its condition
  function automatic logic [2:0] act_eval(input loss_act_t act, input logic cond);
    logic [2:0] r;
    r = 3'h0;
    if (cond) begin
      unique case (act)
        ACT_OFF: r = 3'b000;
        ACT_WARN: r = 3'b001;
        ACT_ALARM: r = 3'b011;
        ACT_TRIP: r = 3'b100;
      endcase
    end
    return r;
  endfunction

  always_comb begin
    if (sel2 <= SEL_ACT_MAX) begin
      path = act_eval(act1, loss[0]) | act_eval(loss_act_t'(sel2[1:0]), loss[1]);
    end else if (sel2 == SEL_BOTH) begin
      path = act_eval(act1, loss[0] && loss[1]);
    end else begin
      path = act_eval(act1, loss[0] || loss[1]);
    end
  end

  assign trip_req = (path[2] && drive_running && !drive_reset_active)
                    || (cyclic_active && |loss);
  assign fault_nxt = trip_req || (fault_r && !clr_link);

  // Warning follows the condition; fault latches until cleared
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      warn_r <= 1'b0;
      alarm_r <= 1'b0;
      fault_r <= 1'b0;
      panel_r <= PANEL_NONE;
    end else begin
      warn_r <= path[0];
      fault_r <= fault_nxt;
      alarm_r <= path[1] || (fault_nxt && cfg_loss_r[STOP_BIT] == STOP_ALARM);
      if (fault_nxt) begin
        panel_r <= PANEL_FAULT;
      end else if (path[0]) begin
        panel_r <= PANEL_WARN;
      end else begin
        panel_r <= PANEL_NONE;
      end
    end
  end

  // ********************************
  // Network diagnosis
  // ********************************
  assign snmp_sel = diag_sel == DIAG_SNMP || diag_sel == SEL_ANY;
  assign dup_en = diag_sel == DIAG_DUP || diag_sel == SEL_ANY;
  assign slot_block = slot01_r[15:0] == SLOT_NO_SNMP || slot01_r[31:16] == SLOT_NO_SNMP
                      || slot23_r[15:0] == SLOT_NO_SNMP || slot23_r[31:16] == SLOT_NO_SNMP;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      snmp_r <= 1'b0;
      dup_req_r <= 1'b0;
      dup_r <= 1'b0;
    end else begin
      snmp_r <= snmp_sel && !slot_block;
      dup_req_r <= dup_en && |link_rise;
      dup_r <= (dup_en && dup_ip_detected) || (dup_r && !clr_dup);
    end
  end

  // ********************************
  // Relay during drive reset
  // ********************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_chg_r <= 1'b0;
      reset_prev_r <= 1'b0;
      relay_r <= 1'b1;
    end else begin
      reset_prev_r <= drive_reset_active;
      cfg_chg_r <= speed_cfg_changed || ip_cfg_changed || (cfg_chg_r && !(reset_prev_r && !drive_reset_active));
      relay_r <= !drive_reset_active
                 || (relay_sel == SEL_OFF && !cfg_chg_r && !speed_cfg_changed && !ip_cfg_changed);
    end
  end

  // ********************************
  // Keepalive
  // ********************************
  assign ka.tcp_open = tcp_open;
  assign ka.peer_resp = peer_response;
  assign ka.interval = ka_interval_r;

  tcp_keepalive u_keepalive (
    .pclk(pclk),
    .presetn(presetn),
    .ka(ka.timer)
  );

  // ********************************
  // Interrupts
  // ********************************
  assign irq_evt = {ka.force_close, ka.probe, dup_ip_detected && dup_en, path[0] && !warn_r, trip_req};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_r <= '0;
      irq_r <= 1'b0;
    end else begin
      if (wr_en && paddr == ADDR_IRQ_STAT) begin
        irq_stat_r <= (irq_stat_r & ~pwdata[IRQ_W-1:0]) | irq_evt;
      end else begin
        irq_stat_r <= irq_stat_r | irq_evt;
      end
      irq_r <= |(irq_stat_r & irq_mask_r);
    end
  end

  // ********************************
  // Outputs
  // ********************************
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign link_loss_warning = warn_r;
  assign alarm_output = alarm_r;
  assign link_loss_fault = fault_r;
  assign panel_code = panel_r;
  assign duplicate_addr_fault = dup_r;
  assign dup_check_req = dup_req_r;
  assign snmp_enable = snmp_r;
  assign relay_enable = relay_r;
  assign keepalive_send = ka.probe;
  assign tcp_force_close = ka.force_close;
  assign irq = irq_r;

  // ********************************
  // Assertions
  // ********************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_OFF_NO_WARN: assert property ((act1 == ACT_OFF && sel2 == SEL_ANY) |=> !link_loss_warning)
    else $error("warning raised with detection off");
  AST_ALARM_ACT: assert property ((act1 == ACT_ALARM && sel2 == SEL_ANY && |loss) |=> alarm_output && link_loss_warning)
    else $error("alarm missing for warning and alarm action");
  AST_PORT_SPLIT: assert property ((act1 == ACT_OFF && sel2 == 16'h0001 && loss == 2'b01) |=> !link_loss_warning)
    else $error("port one loss used second-port action");
  AST_BOTH_PORTS: assert property ((act1 == ACT_WARN && sel2 == SEL_BOTH && loss == 2'b10) |=> !link_loss_warning)
    else $error("single port loss acted in both-ports mode");
  AST_EITHER_PORT: assert property ((act1 == ACT_WARN && sel2 == SEL_ANY && loss == 2'b10) |=> link_loss_warning)
    else $error("either-port loss not acted on");
  AST_STOP_NO_TRIP: assert property ((!drive_running && !cyclic_active && !link_loss_fault) |=> !link_loss_fault)
    else $error("trip while drive stopped");
  AST_TRIP_ALARM: assert property ((trip_req && cfg_loss_r[STOP_BIT] == STOP_ALARM) |=> alarm_output && panel_code == PANEL_FAULT)
    else $error("trip indication does not follow stop mode");
  AST_CYCLIC_TRIP: assert property ((cyclic_active && |loss) |=> link_loss_fault [*2])
    else $error("cyclic loss did not trip");
  AST_DUP_TRIP: assert property ((dup_en && dup_ip_detected) |=> duplicate_addr_fault)
    else $error("duplicate address not tripped");
  AST_SNMP_BLOCK: assert property (slot_block |=> !snmp_enable)
    else $error("SNMP on with blocking function slot");
  AST_RELAY_STOP: assert property ((drive_reset_active && relay_sel == SEL_ANY) |=> !relay_enable)
    else $error("relay kept during reset when stop selected");
  AST_RELAY_CHG: assert property ((drive_reset_active && cfg_chg_r) |=> !relay_enable)
    else $error("relay kept during reset after setting change");
endmodule

/* File: rtl/link_sup_pkg.sv */
// Constants and types of the Ethernet link-loss supervisor
package link_sup_pkg;
  // ********************************
  // Register map
  // ********************************
  localparam logic [7:0] ADDR_CFG_LOSS = 8'h00;
  localparam logic [7:0] ADDR_CFG_NET = 8'h04;
  localparam logic [7:0] ADDR_KA_INTERVAL = 8'h08;
  localparam logic [7:0] ADDR_SLOT01 = 8'h0C;
  localparam logic [7:0] ADDR_SLOT23 = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h18;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h1C;
  localparam logic [7:0] ADDR_CMD = 8'h20;
  // ********************************
  // Field positions and reset values
  // ********************************
  localparam int SEL2_LSB = 0;
  localparam int ACT_LSB = 16;
  localparam int STOP_BIT = 18;
  localparam int DIAG_LSB = 0;
  localparam int RELAY_LSB = 16;
  localparam int CMD_CLR_LINK = 0;
  localparam int CMD_CLR_DUP = 1;
  localparam logic [31:0] CFG_LOSS_RST = 32'h0003270F;
  localparam logic [31:0] CFG_NET_RST = 32'h00000000;
  localparam logic [31:0] KA_INTERVAL_RST = 32'h000003E8;
  localparam logic [31:0] SLOT_RST = 32'h270F270F;
  localparam logic [4:0] IRQ_MASK_RST = 5'h00;
  // ********************************
  // Selector codes
  // ********************************
  localparam logic [15:0] SEL_OFF = 16'h0000;
  localparam logic [15:0] SEL_ACT_MAX = 16'h0003;
  localparam logic [15:0] SEL_BOTH = 16'h22B8;
  localparam logic [15:0] SEL_ANY = 16'h270F;
  localparam logic [15:0] DIAG_SNMP = 16'h0001;
  localparam logic [15:0] DIAG_DUP = 16'h0002;
  localparam logic [15:0] SLOT_NO_SNMP = 16'h8892;
  localparam logic STOP_ALARM = 1'b0;
  localparam logic [2:0] KA_MAX_PROBES = 3'h7;
  // Interrupt bit positions
  localparam int IRQ_LINK_FAULT = 0;
  localparam int IRQ_WARN = 1;
  localparam int IRQ_DUP = 2;
  localparam int IRQ_PROBE = 3;
  localparam int IRQ_CLOSE = 4;
  localparam int IRQ_W = 5;
  typedef enum logic [1:0] {
    ACT_OFF = 2'b00,
    ACT_WARN = 2'b01,
    ACT_ALARM = 2'b10,
    ACT_TRIP = 2'b11
  } loss_act_t;
  typedef enum logic [1:0] {
    PANEL_NONE = 2'b00,
    PANEL_WARN = 2'b01,
    PANEL_FAULT = 2'b10
  } panel_t;
endpackage

/* File: rtl/keepalive_if.sv */
// Signals between the supervisor and its keepalive timer
`timescale 1ns/1ns
interface keepalive_if;
  logic tcp_open;
  logic peer_resp;
  logic [31:0] interval;
  logic probe;
  logic force_close;
  logic [2:0] probe_cnt;
  modport ctl (output tcp_open, peer_resp, interval, input probe, force_close, probe_cnt);
  modport timer (input tcp_open, peer_resp, interval, output probe, force_close, probe_cnt);
endinterface

/* File: rtl/tcp_keepalive.sv */
// TCP keepalive timer with alive-check count and forced close
`timescale 1ns/1ns
module tcp_keepalive
  import link_sup_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control side
  keepalive_if.timer ka
);
  logic [31:0] timer_r;
  logic [2:0] cnt_r;
  logic probe_r;
  logic close_r;
  logic expired;

  assign expired = ka.tcp_open && !ka.peer_resp && (timer_r + 32'h1 >= ka.interval);

  // Silence timer restarts on every response and every expiry
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_r <= 32'h0;
    end else if (!ka.tcp_open || ka.peer_resp || expired) begin
      timer_r <= 32'h0;
    end else begin
      timer_r <= timer_r + 32'h1;
    end
  end

  // Alive checks are counted; the expiry after the seventh closes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 3'h0;
      probe_r <= 1'b0;
      close_r <= 1'b0;
    end else begin
      probe_r <= expired && (cnt_r != KA_MAX_PROBES);
      close_r <= expired && (cnt_r == KA_MAX_PROBES);
      if (!ka.tcp_open || ka.peer_resp || (expired && cnt_r == KA_MAX_PROBES)) begin
        cnt_r <= 3'h0;
      end else if (expired) begin
        cnt_r <= cnt_r + 3'h1;
      end
    end
  end

  assign ka.probe = probe_r;
  assign ka.force_close = close_r;
  assign ka.probe_cnt = cnt_r;

  // ********************************
  // Assertions
  // ********************************
  sequence s_expire;
    expired && cnt_r != KA_MAX_PROBES;
  endsequence
  sequence s_last_expire;
    expired && cnt_r == KA_MAX_PROBES;
  endsequence

  AST_PROBE_ON_SILENCE: assert property (@(posedge pclk) disable iff (!presetn)
    s_expire |=> probe_r && !close_r)
    else $error("alive check not sent after silent interval");
  AST_CLOSE_AFTER_SEVEN: assert property (@(posedge pclk) disable iff (!presetn)
    s_last_expire |=> close_r && !probe_r ##1 cnt_r == 3'h0)
    else $error("connection not closed after seventh check");
  AST_CLOSE_CAUSE: assert property (@(posedge pclk) disable iff (!presetn)
    close_r |-> $past(cnt_r) == KA_MAX_PROBES)
    else $error("forced close before seven checks");
endmodule

/* File: bench/phy_peer_model.sv */
// Behavioural model of the two PHY ports and the remote TCP peer
`timescale 1ns/1ns
module phy_peer_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Scenario controls
  input wire logic cut1,
  input wire logic cut2,
  input wire logic peer_alive,
  input wire logic dup_req,
  input wire logic tcp_open,
  // Toward the supervisor
  output logic first_eth_port_link_up,
  output logic second_eth_port_link_up,
  output logic peer_response,
  output logic dup_ip_detected
);
  logic [1:0] gap_r;
  // ********************************
  // Link pins and peer answers
  // ********************************
  // Peer answers every third cycle, faster than any interval the bench sets
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_eth_port_link_up <= 1'b1;
      second_eth_port_link_up <= 1'b1;
      peer_response <= 1'b0;
      dup_ip_detected <= 1'b0;
      gap_r <= 2'h0;
    end else begin
      first_eth_port_link_up <= !cut1;
      second_eth_port_link_up <= !cut2;
      gap_r <= (gap_r == 2'h2) ? 2'h0 : gap_r + 2'h1;
      peer_response <= peer_alive && tcp_open && (gap_r == 2'h2);
      dup_ip_detected <= dup_req;
    end
  end
endmodule

/* File: bench/tb_top.sv */
// Self-checking testbench of the link-loss supervisor
`timescale 1ns/1ns
module tb_top;
  import link_sup_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, e, first_eth_port_link_up, second_eth_port_link_up, peer_response, dup_ip_detected;
  logic drive_running = 1'b0, drive_reset_active = 1'b0, cyclic_active = 1'b0;
  logic speed_cfg_changed = 1'b0, ip_cfg_changed = 1'b0, tcp_open = 1'b0;
  logic cut1 = 1'b0, cut2 = 1'b0, peer_alive = 1'b0, dup_req = 1'b0;
  logic link_loss_warning, alarm_output, link_loss_fault, duplicate_addr_fault, dup_check_req;
  logic snmp_enable, relay_enable, keepalive_send, tcp_force_close, irq;
  panel_t panel_code;
  int n_mismatch = 0, n_compared = 0, n_send = 0, n_close = 0, n_dreq = 0;
  integer seed = 32'hD5222D43;
  logic [15:0] sel_tab [6] = '{16'h0000, 16'h0001, 16'h0002, 16'h0003, 16'h22B8, 16'h270F};
  logic [15:0] dsel [4] = '{16'h0000, 16'h0001, 16'h0002, 16'h270F};

  always #5 pclk = ~pclk;

  link_loss_supervisor DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .first_eth_port_link_up(first_eth_port_link_up), .second_eth_port_link_up(second_eth_port_link_up), .drive_running(drive_running),
    .drive_reset_active(drive_reset_active), .cyclic_active(cyclic_active), .speed_cfg_changed(speed_cfg_changed),
    .ip_cfg_changed(ip_cfg_changed), .tcp_open(tcp_open), .peer_response(peer_response),
    .dup_ip_detected(dup_ip_detected), .link_loss_warning(link_loss_warning), .alarm_output(alarm_output),
    .link_loss_fault(link_loss_fault), .panel_code(panel_code), .duplicate_addr_fault(duplicate_addr_fault),
    .dup_check_req(dup_check_req), .snmp_enable(snmp_enable), .relay_enable(relay_enable),
    .keepalive_send(keepalive_send), .tcp_force_close(tcp_force_close), .irq(irq));

  phy_peer_model peer (.pclk(pclk), .presetn(presetn), .cut1(cut1), .cut2(cut2), .peer_alive(peer_alive),
    .dup_req(dup_req), .tcp_open(tcp_open), .first_eth_port_link_up(first_eth_port_link_up), .second_eth_port_link_up(second_eth_port_link_up),
    .peer_response(peer_response), .dup_ip_detected(dup_ip_detected));

  // ********************************
  // Pulse counters and checks
  // ********************************
  always @(posedge pclk) begin
    if (keepalive_send === 1'b1) n_send++;
    if (tcp_force_close === 1'b1) n_close++;
    if (dup_check_req === 1'b1) n_dreq++;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask

  task end_of_test;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // APB transfer, holds the request until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    logic rdy;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    rdy = 1'b0;
    k = 0;
    while (!rdy && k < 50) begin
      @(posedge pclk);
      rdy = (pready === 1'b1);
      q = prdata;
      e = pslverr;
      k++;
    end
    psel <= 1'b0;
    penable <= 1'b0;
    if (!rdy) begin
      chk(1'b0, 1'b1, "apb answer timeout");
      end_of_test;
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string m);
    apb(1'b0, a, 32'h0);
    chk(q, exp, m);
  endtask

  // Expected {warning, alarm, fault, panel} for one loss setting
  function automatic logic [4:0] exp_loss(int a, int s, bit l1, bit l2, bit run, bit stp);
    int x1, x2;
    logic w, f, al;
    x1 = 0;
    x2 = 0;
    if (s <= 3) begin
      x1 = l1 ? a : 0;
      x2 = l2 ? s : 0;
    end else if (s == 8888) begin
      x1 = (l1 && l2) ? a : 0;
    end else begin
      x1 = (l1 || l2) ? a : 0;
    end
    w = (x1 == 1) || (x1 == 2) || (x2 == 1) || (x2 == 2);
    f = run && ((x1 == 3) || (x2 == 3));
    al = (x1 == 2) || (x2 == 2) || (f && !stp);
    return {w, al, f, f ? 2'h2 : (w ? 2'h1 : 2'h0)};
  endfunction

  initial begin
    repeat (100000) @(posedge pclk);
    chk(1'b0, 1'b1, "run timeout");
    end_of_test;
  end

  // ********************************
  // Main sequence
  // ********************************
  initial begin
    logic [31:0] r;
    int sb, dn, k;
    bit en, sn;
    cyc(16);
    presetn <= 1'b1;
    cyc(3);
    chk(relay_enable, 1'b1, "relay after reset");
    rd(ADDR_CFG_LOSS, 32'h0003270F, "loss config reset");
    rd(ADDR_CFG_NET, 32'h0, "net config reset");
    rd(ADDR_KA_INTERVAL, 32'd1000, "interval reset");
    rd(ADDR_SLOT01, 32'h270F270F, "slot reset");
    rd(ADDR_IRQ_MASK, 32'h0, "mask reset");
    rd(ADDR_STATUS, 32'h00000203, "status reset");
    rd(8'h40, 32'h0, "unmapped read data");
    chk(e, 1'b1, "unmapped error");
    for (int a = 0; a < 4; a++) begin
      for (int s = 0; s < 6; s++) begin
        r = $random(seed);
        apb(1'b1, ADDR_CFG_LOSS, {13'h0, r[0], a[1:0], sel_tab[s]});
        drive_running <= r[1];
        drive_reset_active <= r[2] & r[3];
        cut1 <= r[4];
        cut2 <= r[5];
        cyc(6);
        @(negedge pclk);
        chk({link_loss_warning, alarm_output, link_loss_fault, panel_code},
            exp_loss(a, sel_tab[s], r[4], r[5], r[1] && !(r[2] & r[3]), r[0]), "loss outputs");
        cyc(1);
        cut1 <= 1'b0;
        cut2 <= 1'b0;
        drive_reset_active <= 1'b0;
        cyc(6);
        apb(1'b1, ADDR_CMD, 32'h1);
        apb(1'b1, ADDR_IRQ_STAT, 32'h1F);
        cyc(2);
        @(negedge pclk);
        chk({link_loss_warning, link_loss_fault}, 2'h0, "loss cleared");
      end
    end
    apb(1'b1, ADDR_CFG_LOSS, 32'h0000270F);
    drive_running <= 1'b0;
    cyclic_active <= 1'b1;
    cut2 <= 1'b1;
    cyc(6);
    @(negedge pclk);
    chk(link_loss_fault, 1'b1, "cyclic trip");
    cyc(1);
    cut2 <= 1'b0;
    cyclic_active <= 1'b0;
    cyc(6);
    apb(1'b1, ADDR_CMD, 32'h1);
    for (int d = 0; d < 4; d++) begin
      for (int sl = 0; sl < 2; sl++) begin
        apb(1'b1, ADDR_CFG_NET, {16'h0, dsel[d]});
        apb(1'b1, ADDR_SLOT23, sl ? 32'h8892270F : 32'h270F270F);
        dn = n_dreq;
        cut1 <= 1'b1;
        cyc(6);
        cut1 <= 1'b0;
        cyc(6);
        dup_req <= 1'b1;
        cyc(1);
        dup_req <= 1'b0;
        cyc(4);
        @(negedge pclk);
        en = (d == 2) || (d == 3);
        sn = ((d == 1) || (d == 3)) && (sl == 0);
        chk(snmp_enable, sn, "snmp enable");
        chk(duplicate_addr_fault, en, "duplicate fault");
        chk(n_dreq - dn, en, "duplicate check on link-up");
        cyc(1);
        apb(1'b1, ADDR_CMD, 32'h2);
        apb(1'b1, ADDR_IRQ_STAT, 32'h1F);
      end
    end
    apb(1'b1, ADDR_CFG_NET, 32'h0);
    for (int i = 0; i < 2; i++) begin
      speed_cfg_changed <= (i == 0);
      ip_cfg_changed <= (i == 1);
      cyc(1);
      speed_cfg_changed <= 1'b0;
      ip_cfg_changed <= 1'b0;
      cyc(2);
      drive_reset_active <= 1'b1;
      cyc(3);
      @(negedge pclk);
      chk(relay_enable, 1'b0, "relay after setting change");
      cyc(1);
      drive_reset_active <= 1'b0;
      cyc(3);
      drive_reset_active <= 1'b1;
      cyc(3);
      @(negedge pclk);
      chk(relay_enable, 1'b1, "relay kept in reset");
      cyc(1);
      drive_reset_active <= 1'b0;
      cyc(2);
    end
    apb(1'b1, ADDR_CFG_NET, 32'h270F0000);
    drive_reset_active <= 1'b1;
    cyc(3);
    @(negedge pclk);
    chk(relay_enable, 1'b0, "relay stopped in reset");
    cyc(1);
    drive_reset_active <= 1'b0;
    apb(1'b1, ADDR_KA_INTERVAL, 32'h4);
    apb(1'b1, ADDR_IRQ_MASK, 32'h08);
    apb(1'b1, ADDR_IRQ_STAT, 32'h1F);
    peer_alive <= 1'b1;
    tcp_open <= 1'b1;
    cyc(40);
    @(negedge pclk);
    chk(n_send, 0, "no check while peer answers");
    cyc(1);
    peer_alive <= 1'b0;
    sb = n_send;
    for (k = 0; k < 200 && n_close == 0; k++) cyc(1);
    tcp_open <= 1'b0;
    chk(n_send - sb, 7, "alive checks before close");
    chk(n_close, 1, "forced close");
    cyc(2);
    @(negedge pclk);
    chk(irq, 1'b1, "irq raised");
    rd(ADDR_IRQ_STAT, 32'h18, "irq status");
    apb(1'b1, ADDR_IRQ_MASK, 32'h0);
    cyc(1);
    @(negedge pclk);
    chk(irq, 1'b0, "irq masked");
    apb(1'b1, ADDR_IRQ_STAT, 32'h18);
    rd(ADDR_IRQ_STAT, 32'h0, "irq status cleared");
    end_of_test;
  end
endmodule
